// file: rtl/dscr_consts.svh
// Offsets, field positions and reset values of the DMA status and CRC registers
`ifndef DSCR_CONSTS_SVH
`define DSCR_CONSTS_SVH
// ----------------------------------------
// Register map (byte addresses, aligned words)
// ----------------------------------------
`define DSCR_OFS_W 8
`define DSCR_OFS_STAT 8'h00
`define DSCR_OFS_ADDR 8'h04
`define DSCR_OFS_CRC 8'h08
`define DSCR_ADR_HIGH_ZERO 24'h00_0000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSCR_ST_DIR 3
`define DSCR_ST_CH_HI 2
`define DSCR_ST_CH_LO 0
`define DSCR_CC_BYTE_ORDER_SELECT_HI 29
`define DSCR_CC_BYTE_ORDER_SELECT_LO 28
`define DSCR_CC_WBO 27
`define DSCR_CC_BIT_REFLECT_SELECT 24
`define DSCR_CC_POLYNOMIAL_LENGTH_HI 12
`define DSCR_CC_POLYNOMIAL_LENGTH_LO 8
`define DSCR_CC_EN 7
`define DSCR_CC_APP 6
`define DSCR_CC_TYP 5
`define DSCR_CC_CH_HI 2
`define DSCR_CC_CH_LO 0
// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define DSCR_CRC_WMASK 32'h3900_1FE7
`define DSCR_WORD_RST 32'h0000_0000
`define DSCR_CH_RST 3'h0
`define DSCR_ALIGNED 2'h0
`endif

// file: rtl/dscr_pkg.sv
// Types shared by the DMA status and CRC control register block
package dscr_pkg;
  typedef enum logic [1:0] {
    DSCR_IDLE = 2'b00,
    DSCR_ACK = 2'b01,
    DSCR_ERR = 2'b10
  } dscr_wb_state_type;

  typedef enum logic [1:0] {
    DSCR_ORD_NONE = 2'b00,
    DSCR_ORD_WORD = 2'b01,
    DSCR_ORD_HALF = 2'b10,
    DSCR_ORD_HBYTE = 2'b11
  } dscr_order_type;

  typedef struct packed {
    logic valid;
    logic isRead;
    logic [2:0] chan;
    logic [31:0] addr;
  } dscr_access_type;

  typedef struct packed {
    dscr_order_type byteOrderSelect;
    logic writeReorderSelect;
    logic bitReflectSelect;
    logic [4:0] polynomialLength;
    logic crcRouteEnable;
    logic crcAppendMode;
    logic crcKindSelect;
    logic [2:0] crcChannelSelect;
  } dscr_crc_cfg_type;
endpackage

// file: rtl/dscr_wb_slave.sv
// Classic Wishbone handshake: one-cycle ack or err per request
`timescale 1ns/1ps
module dscr_wb_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus request
  input wire logic cyc,
  input wire logic stb,
  input wire logic hit,
  // Answer
  output logic ack,
  output logic err,
  output logic take
);
  dscr_pkg::dscr_wb_state_type state_ff;
  dscr_pkg::dscr_wb_state_type nxt_state;

  // A new request is only seen from idle, so ack never stretches
  assign take = cyc && stb && (state_ff == dscr_pkg::DSCR_IDLE);

  always_comb begin
    case (state_ff)
      dscr_pkg::DSCR_IDLE: begin
        if (take) begin
          nxt_state = hit ? dscr_pkg::DSCR_ACK : dscr_pkg::DSCR_ERR;
        end else begin
          nxt_state = dscr_pkg::DSCR_IDLE;
        end
      end
      default: nxt_state = dscr_pkg::DSCR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= dscr_pkg::DSCR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ack = (state_ff == dscr_pkg::DSCR_ACK);
  assign err = (state_ff == dscr_pkg::DSCR_ERR);
endmodule

// file: rtl/dscr_byte_order.sv
// Byte reordering of one 32-bit word
`timescale 1ns/1ps
module dscr_byte_order (
  // Selection
  input dscr_pkg::dscr_order_type order,
  // Data
  input wire logic [31:0] wordIn,
  output logic [31:0] wordOut
);
  wire [7:0] b0 = wordIn[7:0];
  wire [7:0] b1 = wordIn[15:8];
  wire [7:0] b2 = wordIn[23:16];
  wire [7:0] b3 = wordIn[31:24];
  wire [31:0] revWord = {b0, b1, b2, b3};
  wire [31:0] swapHalf = {b1, b0, b3, b2};
  wire [31:0] revHalf = {b2, b3, b0, b1};

  always_comb begin
    case (order)
      dscr_pkg::DSCR_ORD_NONE: wordOut = wordIn;
      dscr_pkg::DSCR_ORD_WORD: wordOut = revWord;
      dscr_pkg::DSCR_ORD_HALF: wordOut = swapHalf;
      dscr_pkg::DSCR_ORD_HBYTE: wordOut = revHalf;
      default: wordOut = wordIn;
    endcase
  end
endmodule

// file: rtl/dscr_regs.sv
// DMA global status, last-address and CRC control registers on Wishbone
`timescale 1ns/1ps
`include "dscr_consts.svh"
module dscr_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // DMA bus access report
  input dscr_pkg::dscr_access_type dmaAccess,
  // Channel transfer datapath
  input wire logic xferValid,
  input wire logic [2:0] xferChan,
  input wire logic [1:0] xferAddrLow,
  input wire logic [31:0] xferData,
  output logic crcRouteHit,
  output logic unalignedRefuse,
  output logic crcFeedValid,
  output logic [31:0] crcFeedData,
  output logic [31:0] destData,
  // CRC engine configuration
  output dscr_pkg::dscr_crc_cfg_type crcCfg
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic lastDir_ff;
  logic [2:0] lastChan_ff;
  logic [31:0] lastAddr_ff;
  logic [31:0] crcCtl_ff;
  logic [31:0] rdData_ff;
  logic feedValid_ff;
  logic [31:0] feedData_ff;
  logic [31:0] destData_ff;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [`DSCR_OFS_W-1:0] regOfs = wb_adr_i[`DSCR_OFS_W-1:0];
  wire highZero = (wb_adr_i[31:`DSCR_OFS_W] == `DSCR_ADR_HIGH_ZERO);
  wire statSel = highZero && (regOfs == `DSCR_OFS_STAT);
  wire addrSel = highZero && (regOfs == `DSCR_OFS_ADDR);
  wire crcSel = highZero && (regOfs == `DSCR_OFS_CRC);
  wire anySel = statSel || addrSel || crcSel;
  wire reqTake;

  dscr_wb_slave u_wb (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cyc(wb_cyc_i),
    .stb(wb_stb_i),
    .hit(anySel),
    .ack(wb_ack_o),
    .err(wb_err_o),
    .take(reqTake)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [31:0] statWord = {28'h000_0000, lastDir_ff, lastChan_ff};
  wire [31:0] rdMux = statSel ? statWord :
                      addrSel ? lastAddr_ff :
                      crcSel ? crcCtl_ff : `DSCR_WORD_RST;
  wire [31:0] nxt_rdData = reqTake ? rdMux : rdData_ff;

  // ----------------------------------------
  // CRC control write
  // ----------------------------------------
  // Write lands at the edge where ack is seen, the address still held
  wire crcWrite = wb_ack_o && wb_we_i && crcSel;
  wire [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] mergedCtl = ((crcCtl_ff & ~laneMask) | (wb_dat_i & laneMask))
                          & `DSCR_CRC_WMASK;
  // Append cannot be held while destination reordering is on
  wire [31:0] appClear = 32'h0000_0001 << `DSCR_CC_APP;
  wire [31:0] guardedCtl = mergedCtl[`DSCR_CC_WBO] ? (mergedCtl & ~appClear)
                           : mergedCtl;
  wire [31:0] nxt_crcCtl = crcWrite ? guardedCtl : crcCtl_ff;

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  assign crcCfg.byteOrderSelect =
    dscr_pkg::dscr_order_type'(crcCtl_ff[`DSCR_CC_BYTE_ORDER_SELECT_HI:`DSCR_CC_BYTE_ORDER_SELECT_LO]);
  assign crcCfg.writeReorderSelect = crcCtl_ff[`DSCR_CC_WBO];
  assign crcCfg.bitReflectSelect = crcCtl_ff[`DSCR_CC_BIT_REFLECT_SELECT];
  // Length only meaningful in LFSR kind; passed through either way
  assign crcCfg.polynomialLength =
    crcCtl_ff[`DSCR_CC_POLYNOMIAL_LENGTH_HI:`DSCR_CC_POLYNOMIAL_LENGTH_LO];
  assign crcCfg.crcKindSelect = crcCtl_ff[`DSCR_CC_TYP];
  assign crcCfg.crcRouteEnable = crcCtl_ff[`DSCR_CC_EN];
  assign crcCfg.crcAppendMode = crcCtl_ff[`DSCR_CC_APP];
  assign crcCfg.crcChannelSelect = crcCtl_ff[`DSCR_CC_CH_HI:`DSCR_CC_CH_LO];

  // ----------------------------------------
  // Last DMA access capture
  // ----------------------------------------
  // Bus writes never reach these; only the DMA report moves them
  wire accSeen = dmaAccess.valid;
  wire nxt_lastDir = accSeen ? dmaAccess.isRead : lastDir_ff;
  wire [2:0] nxt_lastChan = accSeen ? dmaAccess.chan : lastChan_ff;
  wire [31:0] nxt_lastAddr = accSeen ? dmaAccess.addr : lastAddr_ff;

  // ----------------------------------------
  // Channel routing and reordering
  // ----------------------------------------
  assign crcRouteHit = crcCfg.crcRouteEnable
                       && (xferChan == crcCfg.crcChannelSelect);
  wire reorderDest = crcRouteHit && crcCfg.writeReorderSelect;
  // Unaligned transfers under destination reordering are flagged and kept out of the CRC feed
  assign unalignedRefuse = reorderDest && (xferAddrLow != `DSCR_ALIGNED);
  wire [31:0] orderedWord;
  dscr_byte_order u_feed_order (
    .order(crcCfg.byteOrderSelect),
    .wordIn(xferData),
    .wordOut(orderedWord)
  );
  wire [31:0] nxt_destData = reorderDest ? orderedWord : xferData;
  wire nxt_feedValid = xferValid && crcRouteHit && !unalignedRefuse;
  wire [31:0] nxt_feedData = nxt_feedValid ? orderedWord : feedData_ff;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lastDir_ff <= 1'b0;
      lastChan_ff <= `DSCR_CH_RST;
      lastAddr_ff <= `DSCR_WORD_RST;
    end else begin
      lastDir_ff <= nxt_lastDir;
      lastChan_ff <= nxt_lastChan;
      lastAddr_ff <= nxt_lastAddr;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crcCtl_ff <= `DSCR_WORD_RST;
      rdData_ff <= `DSCR_WORD_RST;
    end else begin
      crcCtl_ff <= nxt_crcCtl;
      rdData_ff <= nxt_rdData;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      feedValid_ff <= 1'b0;
      feedData_ff <= `DSCR_WORD_RST;
      destData_ff <= `DSCR_WORD_RST;
    end else begin
      feedValid_ff <= nxt_feedValid;
      feedData_ff <= nxt_feedData;
      destData_ff <= nxt_destData;
    end
  end

  assign wb_dat_o = rdData_ff;
  assign crcFeedValid = feedValid_ff;
  assign crcFeedData = feedData_ff;
  assign destData = destData_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking dscr_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property (
    (reqTake && anySel) |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acked next cycle");

  err_latency_a: assert property (
    (reqTake && !anySel) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused next cycle");

  read_hold_a: assert property (
    !reqTake |=> $stable(wb_dat_o))
    else $error("read data moved without request");

  stat_upper_a: assert property (
    (wb_ack_o && $past(statSel) && !$past(wb_we_i))
    |-> (wb_dat_o[31:4] == 28'h000_0000))
    else $error("status upper bits not zero");

  dir_track_a: assert property (
    dmaAccess.valid |=> (lastDir_ff == $past(dmaAccess.isRead)))
    else $error("direction flag missed access");

  chan_track_a: assert property (
    dmaAccess.valid |=> (lastChan_ff == $past(dmaAccess.chan)))
    else $error("channel field missed access");

  addr_track_a: assert property (
    dmaAccess.valid |=> (lastAddr_ff == $past(dmaAccess.addr)))
    else $error("last address missed access");

  status_hold_a: assert property (
    !dmaAccess.valid |=> $stable(lastAddr_ff) && $stable(lastChan_ff)
    && $stable(lastDir_ff))
    else $error("read-only status moved without access");

  write_ignored_a: assert property (
    (wb_ack_o && wb_we_i && !crcWrite) |=> $stable(crcCtl_ff))
    else $error("control moved on write elsewhere");

  crc_reserved_a: assert property (
    (crcCtl_ff & ~`DSCR_CRC_WMASK) == `DSCR_WORD_RST)
    else $error("reserved control bit set");

  crc_write_a: assert property (
    (crcWrite && (wb_sel_i == 4'hF) && !wb_dat_i[`DSCR_CC_WBO])
    |=> (crcCtl_ff == ($past(wb_dat_i) & `DSCR_CRC_WMASK)))
    else $error("control write not stored");

  crc_readback_a: assert property (
    (wb_ack_o && $past(crcSel) && !$past(wb_we_i))
    |-> (wb_dat_o == $past(crcCtl_ff)))
    else $error("control read data mismatch");

  append_block_a: assert property (
    crcCtl_ff[`DSCR_CC_WBO] |-> !crcCtl_ff[`DSCR_CC_APP])
    else $error("append set with write reorder");

  append_drop_a: assert property (
    (crcWrite && (wb_sel_i == 4'hF) && wb_dat_i[`DSCR_CC_WBO])
    |=> !crcCtl_ff[`DSCR_CC_APP] && crcCtl_ff[`DSCR_CC_WBO])
    else $error("append kept with write reorder");

  route_gate_a: assert property (
    (xferValid && !crcCfg.crcRouteEnable) |=> !crcFeedValid)
    else $error("feed active while CRC disabled");

  feed_route_a: assert property (
    (xferValid && crcRouteHit && !unalignedRefuse) |=> crcFeedValid)
    else $error("routed word not fed");

  feed_hold_a: assert property (
    !nxt_feedValid |=> $stable(crcFeedData))
    else $error("feed data moved without word");

  refuse_block_a: assert property (
    unalignedRefuse |=> !crcFeedValid)
    else $error("unaligned word fed with write reorder");

  plain_feed_a: assert property (
    (nxt_feedValid && crcCfg.byteOrderSelect == dscr_pkg::DSCR_ORD_NONE)
    |=> (crcFeedData == $past(xferData)))
    else $error("unordered feed altered");

  word_swap_a: assert property (
    (nxt_feedValid && crcCfg.byteOrderSelect == dscr_pkg::DSCR_ORD_WORD)
    |=> (crcFeedData == {$past(xferData[7:0]), $past(xferData[15:8]),
         $past(xferData[23:16]), $past(xferData[31:24])}))
    else $error("word byte reversal wrong");

  half_swap_a: assert property (
    (nxt_feedValid && crcCfg.byteOrderSelect == dscr_pkg::DSCR_ORD_HALF)
    |=> (crcFeedData == {$past(xferData[15:0]), $past(xferData[31:16])}))
    else $error("half-word swap wrong");

  half_bytes_a: assert property (
    (nxt_feedValid && crcCfg.byteOrderSelect == dscr_pkg::DSCR_ORD_HBYTE)
    |=> (crcFeedData == {$past(xferData[23:16]), $past(xferData[31:24]),
         $past(xferData[7:0]), $past(xferData[15:8])}))
    else $error("byte swap within half-words wrong");

  dest_plain_a: assert property (
    !reorderDest |=> (destData == $past(xferData)))
    else $error("destination altered without reorder");

  dest_reorder_a: assert property (
    (reorderDest && crcCfg.byteOrderSelect == dscr_pkg::DSCR_ORD_WORD)
    |=> (destData == {$past(xferData[7:0]), $past(xferData[15:8]),
         $past(xferData[23:16]), $past(xferData[31:24])}))
    else $error("destination not reordered");

  read_status_c: cover property (wb_ack_o && $past(statSel) && !$past(wb_we_i));
  write_crc_c: cover property (crcWrite);
  access_seen_c: cover property (dmaAccess.valid ##1 dmaAccess.valid);
  route_feed_c: cover property (crcFeedValid && crcCfg.writeReorderSelect);
  refuse_seen_c: cover property (xferValid && unalignedRefuse);
endmodule

// file: verification/testbench.sv
// Self-checking bench for the DMA status, last-address and CRC control registers
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wbDat;
  logic wbAck, wbErr;
  dscr_pkg::dscr_access_type dmaAcc = '0;
  logic xferValid = 1'b0;
  logic [2:0] xferChan = 3'h0;
  logic [1:0] xferAddrLow = 2'h0;
  logic [31:0] xferData = 32'h0000_0000;
  logic routeHit, refuse, feedValid;
  logic [31:0] feedData, destData;
  dscr_pkg::dscr_crc_cfg_type crcCfg;
  int errorCnt = 0, checked = 0, cycles = 0, seed = 32'h5e343fc2;
  logic [31:0] st = 32'h0000_0000, ad = 32'h0000_0000, cc = 32'h0000_0000, r;
  logic e;

  always #25 ref_clk = ~ref_clk;

  dscr_regs uut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wbDat),
    .wb_ack_o(wbAck), .wb_err_o(wbErr), .dmaAccess(dmaAcc), .xferValid(xferValid),
    .xferChan(xferChan), .xferAddrLow(xferAddrLow), .xferData(xferData),
    .crcRouteHit(routeHit), .unalignedRefuse(refuse), .crcFeedValid(feedValid),
    .crcFeedData(feedData), .destData(destData), .crcCfg(crcCfg));

  // ----------------------------------------
  // Model helpers and checks
  // ----------------------------------------
  function automatic logic [31:0] ord(input logic [1:0] o, input logic [31:0] d);
    case (o)
      2'h1: ord = {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h2: ord = {d[15:0], d[31:16]};
      2'h3: ord = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: ord = d;
    endcase
  endfunction

  task automatic completeRun();
    if (errorCnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Ack sampled at the rising edge; a hang is caught by the cycle ceiling
  task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge ref_clk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
    r = wbDat;
    e = wbErr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(r, x);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic wcc(input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) cc[8*i+:8] = d[8*i+:8];
    cc = cc & 32'h3900_1FE7;
    if (cc[27]) cc[6] = 1'b0;
    wb(1'b1, 32'h0000_0008, d, s);
  endtask

  task automatic dma(input int k);
    logic [3:0] rc;
    logic [31:0] ra;
    repeat (k) begin
      rc = 4'($random(seed));
      ra = $random(seed);
      @(posedge ref_clk);
      dmaAcc <= {1'b1, rc, ra};
      st = {28'h0, rc};
      ad = ra;
    end
    @(posedge ref_clk);
    dmaAcc.valid <= 1'b0;
  endtask

  task automatic xfer(input logic [2:0] ch, input logic [1:0] lo);
    logic hit, ref_;
    hit = cc[7] && ch == cc[2:0];
    ref_ = hit && cc[27] && lo != 2'h0;
    @(posedge ref_clk);
    xferValid <= 1'b1; xferChan <= ch; xferAddrLow <= lo; xferData <= $random(seed);
    @(negedge ref_clk);
    chk({31'h0, routeHit}, {31'h0, hit});
    chk({31'h0, refuse}, {31'h0, ref_});
    @(posedge ref_clk);
    xferValid <= 1'b0;
    @(negedge ref_clk);
    chk({31'h0, feedValid}, {31'h0, hit && !ref_});
    if (hit && !ref_) chk(feedData, ord(cc[29:28], xferData));
    chk(destData, (hit && cc[27]) ? ord(cc[29:28], xferData) : xferData);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errorCnt++;
      completeRun();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(32'h0000_0000, 32'h0000_0000);
    rd(32'h0000_0004, 32'h0000_0000);
    rd(32'h0000_0008, 32'h0000_0000);
    for (int i = 1; i < 7; i++) begin
      dma(i % 3 + 1);
      rd(32'h0000_0000, st);
      rd(32'h0000_0004, ad);
    end
    wb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF, 4'hF);
    wb(1'b1, 32'h0000_0004, 32'h1234_5678, 4'hF);
    rd(32'h0000_0000, st);
    rd(32'h0000_0004, ad);
    // Unmapped offset and nonzero upper address both refused
    wb(1'b0, 32'h0000_000C, 32'h0000_0000, 4'hF);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wb(1'b1, 32'h0000_0108, 32'hFFFF_FFFF, 4'hF);
    chk({31'h0, e}, 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      wcc($random(seed), (i < 5) ? 4'hF : 4'($random(seed)));
      rd(32'h0000_0008, cc);
      chk({17'h0, crcCfg}, {17'h0, cc[29:27], cc[24], cc[12:5], cc[2:0]});
    end
    wcc(32'h0800_0040, 4'hF);
    rd(32'h0000_0008, 32'h0800_0000);
    for (int o = 0; o < 8; o++) begin
      wcc({2'h0, 2'(o >> 1), o[0], 14'h0000, 5'h1F, 1'b1, 4'h0, 3'($random(seed))}, 4'hF);
      xfer(cc[2:0], 2'h0);
      xfer(cc[2:0], 2'h1);
      xfer(cc[2:0] + 3'h1, 2'h0);
    end
    wcc(32'h0000_0000, 4'h1);
    xfer(cc[2:0], 2'h0);
    completeRun();
  end
endmodule
